// ---- timer_gate_params.svh ----
// timer_gate_params.svh: offsets, field positions, reset values for the timer gate block
// assumes: included by bare name from design files; definitions only
`ifndef TIMER_GATE_PARAMS_SVH
`define TIMER_GATE_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_GATE_CONTROL   12'h000
`define OFF_TIMER_CONTROL  12'h004
`define OFF_COUNTER_VALUE  12'h008
`define OFF_IRQ_STATUS     12'h00C
`define OFF_IRQ_MASK       12'h010

// ****************************************
// gate control and timer control field positions
// ****************************************
`define BIT_GATE_ENABLE    7
`define BIT_GATE_POLARITY  6
`define BIT_GATE_TOGGLE    5
`define BIT_GATE_SPM       4
`define BIT_PULSE_PENDING  3
`define BIT_GATE_LEVEL     2
`define BIT_TIMER_ON       0

// ****************************************
// interrupt bits and reset values
// ****************************************
`define IRQ_ACQ_DONE       0
`define IRQ_OVERFLOW       1
`define IRQ_WIDTH          2
`define RST_GATE_CONTROL   4'h0
`define RST_COUNTER        16'h0000
`define RST_IRQ            2'h0

`endif

// ---- timer_gate_pkg.sv ----
// timer_gate_pkg: shared types for the timer gate block
// assumes: nothing beyond the params header
package timer_gate_pkg;

    typedef enum logic [1:0] {
        SP_IDLE   = 2'b00,
        SP_ARMED  = 2'b01,
        SP_ACTIVE = 2'b10
    } sp_state_t;

    typedef logic [2:0] reg_index_t;

endpackage

// ---- reg_access_if.sv ----
// reg_access_if: decoded register access between bus slave and register file
// assumes: single clock hclk; one access per cycle at most
`timescale 1ns/1ps
`default_nettype none

interface reg_access_if;
    logic        wr;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [11:0] raddr;
    logic [31:0] rdata;

    modport slave (output wr, output waddr, output wdata, output raddr, input rdata);
    modport regs  (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ---- ahb_reg_slave.sv ----
// ahb_reg_slave: zero-wait AHB-Lite slave that turns transfers into register accesses
// assumes: single word transfers; the register side answers reads combinationally
`timescale 1ns/1ps
`default_nettype none

module ahb_reg_slave (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    reg_access_if.slave      acc
);
    logic        wr_ph_q;
    logic        wr_ph_d;
    logic        rd_ph_q;
    logic        rd_ph_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic        take;

    // ****************************************
    // address phase capture
    // ****************************************
    // hsize is not checked: only whole words are issued
    assign take = hsel && htrans[1] && hready;

    always_comb begin
        wr_ph_d = take && hwrite;
        rd_ph_d = take && !hwrite;
        addr_d  = take ? haddr[11:0] : addr_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_q <= 1'b0;
            rd_ph_q <= 1'b0;
            addr_q  <= 12'h000;
        end else begin
            wr_ph_q <= wr_ph_d;
            rd_ph_q <= rd_ph_d;
            addr_q  <= addr_d;
        end
    end

    // ****************************************
    // data phase
    // ****************************************
    assign acc.wr    = wr_ph_q;
    assign acc.waddr = addr_q;
    assign acc.wdata = hwdata;
    assign acc.raddr = addr_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rd_ph_q ? acc.rdata : 32'h0000_0000;

    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:12], htrans[0]};
endmodule

`default_nettype wire

// ---- gate_path.sv ----
// gate_path: polarity, toggle flip-flop and single-pulse acquisition of the timer gate
// assumes: gate_in synchronous to hclk; arm is a one-cycle pulse from the register file
`timescale 1ns/1ps
`default_nettype none

module gate_path
    import timer_gate_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic gate_in,
    input  wire logic gate_polarity,
    input  wire logic gate_toggle_mode,
    input  wire logic gate_single_pulse_mode,
    input  wire logic arm,
    output logic      gate_level,
    output logic      pulse_acquire_pending,
    output logic      acq_done
);
    import timer_gate_pkg::*;

    logic      pol_gate;
    logic      pol_q;
    logic      tff_q;
    logic      tff_d;
    logic      pre_gate;
    logic      pre_q;
    logic      pre_rise;
    logic      pre_fall;
    sp_state_t sp_q;
    sp_state_t sp_d;

    // ****************************************
    // polarity and toggle
    // ****************************************
    assign pol_gate = gate_polarity ? gate_in : ~gate_in;

    always_comb begin
        // cleared whenever toggle mode is off
        tff_d = 1'b0;
        if (gate_toggle_mode && pol_gate && !pol_q) begin
            tff_d = ~tff_q;
        end else if (gate_toggle_mode) begin
            tff_d = tff_q;
        end
    end

    assign pre_gate = gate_toggle_mode ? tff_q : pol_gate;
    assign pre_rise = pre_gate && !pre_q;
    assign pre_fall = !pre_gate && pre_q;

    // ****************************************
    // single-pulse acquisition
    // ****************************************
    always_comb begin
        sp_d     = sp_q;
        acq_done = 1'b0;
        case (sp_q)
            SP_IDLE: begin
                if (arm) begin
                    sp_d = SP_ARMED;
                end
            end
            SP_ARMED: begin
                // a gate already active when armed waits for the next edge
                if (pre_rise) begin
                    sp_d = SP_ACTIVE;
                end
            end
            SP_ACTIVE: begin
                if (pre_fall) begin
                    sp_d     = SP_IDLE;
                    acq_done = 1'b1;
                end
            end
            default: begin
                sp_d = SP_IDLE;
            end
        endcase
        // an arming write sets the mode bit in the same cycle, so it is not undone here
        if (!gate_single_pulse_mode && !arm) begin
            sp_d     = SP_IDLE;
            acq_done = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pol_q <= 1'b0;
            tff_q <= 1'b0;
            pre_q <= 1'b0;
            sp_q  <= SP_IDLE;
        end else begin
            pol_q <= pol_gate;
            tff_q <= tff_d;
            pre_q <= pre_gate;
            sp_q  <= sp_d;
        end
    end

    assign pulse_acquire_pending = (sp_q != SP_IDLE);
    // single pulse owns the gate when selected; only the armed pulse passes
    assign gate_level = gate_single_pulse_mode ? (sp_q == SP_ACTIVE) && pre_gate : pre_gate;
endmodule

`default_nettype wire

// ---- timer_gate_control.sv ----
// timer_gate_control: 16-bit timer counter with gate control, AHB-Lite register access
// assumes: hresetn is the power-on reset; gate_in synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "timer_gate_params.svh"

module timer_gate_control
    import timer_gate_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        gate_in,
    output logic             irq
);
    import timer_gate_pkg::*;

    reg_access_if acc ();

    logic                  gate_enable_q;
    logic                  gate_enable_d;
    logic                  gate_polarity_q;
    logic                  gate_polarity_d;
    logic                  gate_toggle_mode_q;
    logic                  gate_toggle_mode_d;
    logic                  gate_single_pulse_mode_q;
    logic                  gate_single_pulse_mode_d;
    logic                  timer_on_q;
    logic                  timer_on_d;
    logic [CNT_W-1:0]      counter_value_q;
    logic [CNT_W-1:0]      counter_value_d;
    logic [`IRQ_WIDTH-1:0] irq_status_q;
    logic [`IRQ_WIDTH-1:0] irq_status_d;
    logic [`IRQ_WIDTH-1:0] irq_mask_q;
    logic [`IRQ_WIDTH-1:0] irq_mask_d;
    logic                  wr_gate;
    logic                  wr_timer;
    logic                  wr_cnt;
    logic                  wr_stat;
    logic                  wr_mask;
    logic                  arm;
    logic                  gate_level;
    logic                  pulse_acquire_pending;
    logic                  acq_done;
    logic                  count_en;
    logic                  overflow;
    logic [7:0]            gate_reg_view;

    // ****************************************
    // bus slave and gate path
    // ****************************************
    ahb_reg_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .acc       (acc)
    );

    gate_path u_gate (
        .hclk                   (hclk),
        .hresetn                (hresetn),
        .gate_in                (gate_in),
        .gate_polarity          (gate_polarity_q),
        .gate_toggle_mode       (gate_toggle_mode_q),
        .gate_single_pulse_mode (gate_single_pulse_mode_q),
        .arm                    (arm),
        .gate_level             (gate_level),
        .pulse_acquire_pending  (pulse_acquire_pending),
        .acq_done               (acq_done)
    );

    // ****************************************
    // write decode
    // ****************************************
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    always_comb begin
        wr_gate  = 1'b0;
        wr_timer = 1'b0;
        wr_cnt   = 1'b0;
        wr_stat  = 1'b0;
        wr_mask  = 1'b0;
        if (!acc.wr) begin
            wr_gate = 1'b0;
        end else if (hit(acc.waddr, `OFF_GATE_CONTROL)) begin
            wr_gate = 1'b1;
        end else if (hit(acc.waddr, `OFF_TIMER_CONTROL)) begin
            wr_timer = 1'b1;
        end else if (hit(acc.waddr, `OFF_COUNTER_VALUE)) begin
            wr_cnt = 1'b1;
        end else if (hit(acc.waddr, `OFF_IRQ_STATUS)) begin
            wr_stat = 1'b1;
        end else if (hit(acc.waddr, `OFF_IRQ_MASK)) begin
            wr_mask = 1'b1;
        end
    end

    // arming needs single-pulse mode set in the same write; the register's current mode bit is not used
    assign arm = wr_gate && acc.wdata[`BIT_PULSE_PENDING] && acc.wdata[`BIT_GATE_SPM];

    // ****************************************
    // control registers
    // ****************************************
    always_comb begin
        gate_enable_d            = gate_enable_q;
        gate_polarity_d          = gate_polarity_q;
        gate_toggle_mode_d       = gate_toggle_mode_q;
        gate_single_pulse_mode_d = gate_single_pulse_mode_q;
        timer_on_d               = timer_on_q;
        irq_mask_d               = irq_mask_q;
        if (wr_gate) begin
            gate_enable_d            = acc.wdata[`BIT_GATE_ENABLE];
            gate_polarity_d          = acc.wdata[`BIT_GATE_POLARITY];
            gate_toggle_mode_d       = acc.wdata[`BIT_GATE_TOGGLE];
            gate_single_pulse_mode_d = acc.wdata[`BIT_GATE_SPM];
        end
        if (wr_timer) begin
            timer_on_d = acc.wdata[`BIT_TIMER_ON];
        end
        if (wr_mask) begin
            irq_mask_d = acc.wdata[`IRQ_WIDTH-1:0];
        end
    end

    // ****************************************
    // counter and interrupt status
    // ****************************************
    // gate enable only matters while the timer runs
    assign count_en = timer_on_q && (!gate_enable_q || gate_level);
    assign overflow = count_en && (&counter_value_q);

    always_comb begin
        counter_value_d = counter_value_q;
        if (wr_cnt) begin
            counter_value_d = acc.wdata[CNT_W-1:0];
        end else if (count_en) begin
            counter_value_d = counter_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        irq_status_d = irq_status_q;
        if (wr_stat) begin
            irq_status_d = irq_status_q & ~acc.wdata[`IRQ_WIDTH-1:0];
        end
        // set after clear so an event in the clearing cycle survives
        if (acq_done) begin
            irq_status_d[`IRQ_ACQ_DONE] = 1'b1;
        end
        if (overflow) begin
            irq_status_d[`IRQ_OVERFLOW] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {gate_enable_q, gate_polarity_q, gate_toggle_mode_q,
             gate_single_pulse_mode_q} <= `RST_GATE_CONTROL;
            timer_on_q      <= 1'b0;
            counter_value_q <= `RST_COUNTER;
            irq_status_q    <= `RST_IRQ;
            irq_mask_q      <= `RST_IRQ;
        end else begin
            gate_enable_q            <= gate_enable_d;
            gate_polarity_q          <= gate_polarity_d;
            gate_toggle_mode_q       <= gate_toggle_mode_d;
            gate_single_pulse_mode_q <= gate_single_pulse_mode_d;
            timer_on_q               <= timer_on_d;
            counter_value_q          <= counter_value_d;
            irq_status_q             <= irq_status_d;
            irq_mask_q               <= irq_mask_d;
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        gate_reg_view                     = 8'h00;
        gate_reg_view[`BIT_GATE_ENABLE]   = gate_enable_q;
        gate_reg_view[`BIT_GATE_POLARITY] = gate_polarity_q;
        gate_reg_view[`BIT_GATE_TOGGLE]   = gate_toggle_mode_q;
        gate_reg_view[`BIT_GATE_SPM]      = gate_single_pulse_mode_q;
        gate_reg_view[`BIT_PULSE_PENDING] = pulse_acquire_pending;
        gate_reg_view[`BIT_GATE_LEVEL]    = gate_level;
    end

    always_comb begin
        acc.rdata = 32'h0000_0000;
        if (hit(acc.raddr, `OFF_GATE_CONTROL)) begin
            acc.rdata[7:0] = gate_reg_view;
        end else if (hit(acc.raddr, `OFF_TIMER_CONTROL)) begin
            acc.rdata[`BIT_TIMER_ON] = timer_on_q;
        end else if (hit(acc.raddr, `OFF_COUNTER_VALUE)) begin
            acc.rdata[CNT_W-1:0] = counter_value_q;
        end else if (hit(acc.raddr, `OFF_IRQ_STATUS)) begin
            acc.rdata[`IRQ_WIDTH-1:0] = irq_status_q;
        end else if (hit(acc.raddr, `OFF_IRQ_MASK)) begin
            acc.rdata[`IRQ_WIDTH-1:0] = irq_mask_q;
        end
    end
endmodule

`default_nettype wire

// ---- gate_source.sv ----
// gate_source: stand-in for the pin or peripheral feeding the timer gate
// assumes: called right after a rising edge of hclk
`timescale 1ns/1ps
`default_nettype none

module gate_source (
    input  wire logic hclk,
    output logic      gate_in
);
    // gate is a plain level synchronous to hclk, low until first driven
    initial gate_in = 1'b0;

    task automatic drive(input logic v, input int n);
        gate_in <= v;
        repeat (n) @(posedge hclk);
    endtask
endmodule

`default_nettype wire

// ---- timer_gate_control_chk.sv ----
// timer_gate_control_chk: port-level assertions for the timer gate block
// assumes: bound to timer_gate_control; one clock hclk
`timescale 1ns/1ps
`default_nettype none
`include "timer_gate_params.svh"

module timer_gate_control_chk #(
    parameter int CNT_W = 16
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        gate_in,
    input wire logic        irq
);
    // ****************************************
    // shadow of written control and mask bits
    // ****************************************
    logic        rd_q;
    logic        wr_q;
    logic [11:0] a_q;
    logic [3:0]  gc_q;
    logic [1:0]  mk_q;
    logic        gcr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q  <= 12'h000;
            gc_q <= 4'h0;
            mk_q <= 2'h0;
        end else begin
            rd_q <= hsel && htrans[1] && hready && !hwrite;
            wr_q <= hsel && htrans[1] && hready && hwrite;
            a_q  <= haddr[11:0];
            if (wr_q && a_q == `OFF_GATE_CONTROL) gc_q <= hwdata[7:4];
            if (wr_q && a_q == `OFF_IRQ_MASK) mk_q <= hwdata[1:0];
        end
    end
    assign gcr = rd_q && (a_q == `OFF_GATE_CONTROL);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_low_zero: assert property (gcr |-> hrdata[1:0] == 2'b00 && hrdata[31:8] == 24'h00_0000)
        else $error("unimplemented control bits not zero");
    chk_gate_follow: assert property (gcr && gc_q[1:0] == 2'b00 |-> hrdata[2] == (gc_q[2] ? gate_in : !gate_in))
        else $error("gate level does not follow gate and polarity");
    chk_spm_off: assert property (gcr && !gc_q[0] && !$past(gc_q[0]) |-> !hrdata[3])
        else $error("pending set without single pulse mode");
    chk_active_pend: assert property (gcr && gc_q[0] && hrdata[2] |-> hrdata[3])
        else $error("single pulse gate open while not pending");
    chk_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
        else $error("read data outside read data phase");
    chk_irq_masked: assert property (mk_q == 2'b00 && $past(mk_q) == 2'b00 |-> !irq)
        else $error("interrupt raised while fully masked");
    chk_reset_clean: assert property ($rose(hresetn) |-> !irq && hrdata == 32'h0000_0000)
        else $error("outputs not quiet after reset");
endmodule

bind timer_gate_control timer_gate_control_chk #(.CNT_W(CNT_W)) u_timer_gate_control_chk (.*);

`default_nettype wire

// ---- timer_gate_control_test.sv ----
// timer_gate_control_test: register-level tests of the timer gate block
// assumes: gate_source partner; single slave so hready is hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "timer_gate_params.svh"

module timer_gate_control_test;
    import timer_gate_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        gate_in;
    logic        irq;
    int          errors;
    int          checks_done;
    int          cyc;
    logic [31:0] v;
    logic [31:0] c1;
    logic [3:0]  cfg [5] = '{4'b0000, 4'b1000, 4'b1111, 4'b1110, 4'b1100};
    int          dl [5] = '{0, 3, 3, 0, 3};

    timer_gate_control u_timer_gate_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gate_in(gate_in), .irq(irq));
    gate_source u_gate_source (.hclk(hclk), .gate_in(gate_in));

    initial hclk = 1'b0;
    always #20 hclk = ~hclk;

    // ****************************************
    // bus and check tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // sampling at the falling edge gives the settled value seen by the next rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        logic r;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do begin @(negedge hclk); r = hreadyout; @(posedge hclk); end while (r !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(negedge hclk); r = hreadyout; q = hrdata; @(posedge hclk); end while (r !== 1'b1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        chk(n, e, q);
    endtask

    task automatic irqc(input logic e);
        @(negedge hclk);
        chk("irq", {31'b0, e}, {31'b0, irq});
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
        errors = 0; checks_done = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // polarity resets low, so an idle low gate reads as active
        rdc(`OFF_GATE_CONTROL, 32'h0000_0004, "gate control reset");
        rdc(`OFF_COUNTER_VALUE, 32'h0000_0000, "counter reset");
        rdc(`OFF_IRQ_MASK, 32'h0000_0000, "mask reset");
        wr(12'h100, 32'hFFFF_FFFF);
        rdc(12'h100, 32'h0000_0000, "unmapped");
        wr(`OFF_GATE_CONTROL, 32'h0000_0003);
        rdc(`OFF_GATE_CONTROL, 32'h0000_0004, "low bits");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            u_gate_source.drive(i[0], 1);
            wr(`OFF_GATE_CONTROL, {24'h00_0000, i[2], i[1], 6'b0});
            rdc(`OFF_GATE_CONTROL, {24'h00_0000, i[2], i[1], 3'b0, i[1] ~^ i[0], 2'b0}, "level");
        end
        $display("test level done");
        for (int k = 0; k < 5; k++) begin
            u_gate_source.drive(cfg[k][0], 1);
            wr(`OFF_GATE_CONTROL, {24'h00_0000, cfg[k][2], cfg[k][1], 6'b0});
            wr(`OFF_TIMER_CONTROL, {31'b0, cfg[k][3]});
            xfer(1'b0, `OFF_COUNTER_VALUE, 32'h0000_0000, c1);
            xfer(1'b0, `OFF_COUNTER_VALUE, 32'h0000_0000, v);
            chk("count step", c1 + dl[k], v);
        end
        $display("test count done");
        u_gate_source.drive(1'b0, 2);
        wr(`OFF_GATE_CONTROL, 32'h0000_00E0);
        rdc(`OFF_GATE_CONTROL, 32'h0000_00E0, "toggle start");
        for (int t = 0; t < 3; t++) begin
            u_gate_source.drive(1'b1, 2);
            u_gate_source.drive(1'b0, 2);
            if (t < 2) rdc(`OFF_GATE_CONTROL, t == 0 ? 32'h0000_00E4 : 32'h0000_00E0, "toggle");
        end
        // flip-flop is left set here, so leaving toggle mode must clear it
        wr(`OFF_GATE_CONTROL, 32'h0000_00C0);
        wr(`OFF_GATE_CONTROL, 32'h0000_00E0);
        rdc(`OFF_GATE_CONTROL, 32'h0000_00E0, "toggle cleared");
        $display("test toggle done");
        wr(`OFF_IRQ_MASK, 32'h0000_0000);
        wr(`OFF_IRQ_STATUS, 32'h0000_0003);
        wr(`OFF_GATE_CONTROL, 32'h0000_00D0);
        wr(`OFF_COUNTER_VALUE, 32'h0000_0000);
        wr(`OFF_GATE_CONTROL, 32'h0000_00D8);
        rdc(`OFF_GATE_CONTROL, 32'h0000_00D8, "armed");
        u_gate_source.drive(1'b1, 6);
        u_gate_source.drive(1'b0, 3);
        rdc(`OFF_GATE_CONTROL, 32'h0000_00D0, "acquired");
        xfer(1'b0, `OFF_COUNTER_VALUE, 32'h0000_0000, c1);
        chk("pulse count", 32'h0000_0005, c1);
        u_gate_source.drive(1'b1, 3);
        u_gate_source.drive(1'b0, 2);
        rdc(`OFF_COUNTER_VALUE, c1, "blocked");
        rdc(`OFF_IRQ_STATUS, 32'h0000_0001, "done flag");
        irqc(1'b0);
        wr(`OFF_IRQ_MASK, 32'h0000_0001);
        irqc(1'b1);
        wr(`OFF_IRQ_STATUS, 32'h0000_0001);
        irqc(1'b0);
        wr(`OFF_GATE_CONTROL, 32'h0000_00D8);
        wr(`OFF_GATE_CONTROL, 32'h0000_00C0);
        rdc(`OFF_GATE_CONTROL, 32'h0000_00C0, "spm off");
        rdc(`OFF_IRQ_STATUS, 32'h0000_0000, "no done");
        // mode and arm in one write, starting from mode off
        wr(`OFF_GATE_CONTROL, 32'h0000_00D8);
        rdc(`OFF_GATE_CONTROL, 32'h0000_00D8, "arm with mode");
        $display("test single pulse done");
        // free run from just below the top so the wrap sets the overflow flag
        wr(`OFF_GATE_CONTROL, 32'h0000_0000);
        wr(`OFF_COUNTER_VALUE, 32'h0000_FFFE);
        rdc(`OFF_IRQ_STATUS, 32'h0000_0002, "overflow flag");
        wr(`OFF_IRQ_MASK, 32'h0000_0003);
        irqc(1'b1);
        $display("test overflow done");
        end_sim();
    end
endmodule

`default_nettype wire
